// ---- design/cbs_bus_side.sv ----
`timescale 1ns/100ps
`include "cbs_consts.svh"

// Contract
// - Write data valid phase 1 through phase 2.
// - Lock asserted only during swap accesses.
// - Lock changes only while memory clock high.
// - Lock and byte/word float when drive disabled.
// - Two phases: clock low, clock and stall high.
// - Tolerate memory clock stretched without limit.
// - Stall input extends accesses by whole cycles.
// - Byte/word high for words, low for bytes.
// - Byte/word valid phase 2 before, through phase 1.
// - Coprocessor instruction drives request low, awaits reply.
// - Absent at first phase 1 end: undefined trap.
// - Sample busy each phase 1 end until low.
// - Output-drive enable low during write cycles.
// - Input-drive enable jointly governs write data drive.
// - Fast interrupt taken when low and enabled.
// - Standard interrupt like fast, lower priority.
// - Mode outputs are inverse of mode bits.
module cbs_bus_side
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic mclk,
    input wire logic stall_req_n,
    input wire logic addr_bus_drive_en,
    input wire logic addr_hold_en,
    input wire logic in_drive_en_n,
    input wire logic copro_absent,
    input wire logic copro_busy,
    input wire logic fast_intr_req_n,
    input wire logic std_intr_req_n,
    input wire cbs_pkg::cbs_xfer_t next_xfer,
    input wire logic swap_instr,
    input wire logic copro_start,
    input wire logic fiq_enable,
    input wire logic irq_enable,
    input wire logic [`CBS_MODE_W-1:0] cpu_mode,
    output cbs_pkg::cbs_ctl_pins_t ctl_pins,
    output logic write_not_read,
    output logic [`CBS_DATA_W-1:0] data_out,
    output logic out_drive_en_n,
    output logic copro_request_n,
    output logic copro_trap,
    output logic copro_done,
    output logic fiq_take,
    output logic irq_take,
    output logic [`CBS_MODE_W-1:0] mode_status_n
);

    // ------------------------------------------------------------------------
    // Phase tracking
    // ------------------------------------------------------------------------
    // The memory clock is sampled as a plain synchronous input, so a stretched
    // phase simply means no edge is seen; nothing here counts on its rate.
    logic mclk_q;
    logic ph2_q;
    cbs_pkg::cbs_cp_state_t cp_state;
    cbs_pkg::cbs_cp_state_t next_cp_state;
    logic [`CBS_SYNC_W-1:0] irq_sync;

    wire ph2 = mclk & stall_req_n;
    // A cycle ends only when a true phase 2 gives way to phase 1, so a low
    // stall input repeats the whole cycle instead of cutting it short.
    wire cyc_end = ph2_q & ~mclk;
    wire ph1_end = mclk & ~mclk_q;
    wire addr_open = mclk & addr_hold_en;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            mclk_q <= 1'b0;
            ph2_q <= 1'b0;
        end
        else
        begin
            mclk_q <= mclk;
            ph2_q <= ph2;
        end
    end

    // ------------------------------------------------------------------------
    // Address-timed controls
    // ------------------------------------------------------------------------
    // The values follow the next transfer while the clock is high and the hold
    // enable is open, behaving like the transparent latch on the address;
    // the enables track addr_bus_drive_en on every clock.
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            ctl_pins <= '0;
            write_not_read <= 1'b0;
        end
        else
        begin
            ctl_pins.bw_oe <= addr_bus_drive_en;
            ctl_pins.lock_oe <= addr_bus_drive_en;
            if (addr_open)
            begin
                ctl_pins.bw_n <= next_xfer.word;
                ctl_pins.lock <= swap_instr;
                write_not_read <= next_xfer.write;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Write data and drive enable
    // ------------------------------------------------------------------------
    wire next_drive_n = ~(write_not_read & ~in_drive_en_n);

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            data_out <= `CBS_DATA_RST;
            out_drive_en_n <= 1'b1;
        end
        else if (cyc_end)
        begin
            // Loaded on entry to phase 1 and held to the next cycle end.
            if (write_not_read)
                data_out <= next_xfer.wdata;
            out_drive_en_n <= next_drive_n;
        end
    end

    // ------------------------------------------------------------------------
    // Coprocessor handshake
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_cp_state = cp_state;
        case (cp_state)
            cbs_pkg::CBS_CP_IDLE:
                if (copro_start && cyc_end)
                    next_cp_state = cbs_pkg::CBS_CP_REQ;
            cbs_pkg::CBS_CP_REQ:
                if (ph1_end)
                begin
                    if (copro_absent || !copro_busy)
                        next_cp_state = cbs_pkg::CBS_CP_IDLE;
                    else
                        next_cp_state = cbs_pkg::CBS_CP_WAIT;
                end
            cbs_pkg::CBS_CP_WAIT:
                if (ph1_end && !copro_busy)
                    next_cp_state = cbs_pkg::CBS_CP_IDLE;
            default:
                next_cp_state = cbs_pkg::CBS_CP_IDLE;
        endcase
    end

    wire cp_req = cp_state == cbs_pkg::CBS_CP_REQ;
    wire cp_wait = cp_state == cbs_pkg::CBS_CP_WAIT;
    wire trap_now = cp_req & ph1_end & copro_absent;
    wire done_now = (cp_req | cp_wait) & ph1_end & ~copro_busy & ~trap_now;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            cp_state <= cbs_pkg::CBS_CP_IDLE;
            copro_request_n <= 1'b1;
            copro_trap <= 1'b0;
            copro_done <= 1'b0;
        end
        else
        begin
            cp_state <= next_cp_state;
            copro_request_n <= next_cp_state == cbs_pkg::CBS_CP_IDLE;
            copro_trap <= trap_now;
            copro_done <= done_now;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts and mode
    // ------------------------------------------------------------------------
    // Bit 1 carries the fast request, bit 0 the standard one.
    cbs_sync u_irq_sync
    (
        .clock(clock),
        .rst_b(rst_b),
        .async_in({fast_intr_req_n, std_intr_req_n}),
        .sync_out(irq_sync)
    );

    wire fiq_now = ~irq_sync[1] & fiq_enable;
    wire irq_now = ~irq_sync[0] & irq_enable & ~fiq_now;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            fiq_take <= 1'b0;
            irq_take <= 1'b0;
            mode_status_n <= `CBS_MODE_N_RST;
        end
        else
        begin
            fiq_take <= fiq_now;
            irq_take <= irq_now;
            mode_status_n <= ~cpu_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    sequence cp_first_sample;
        cp_req && ph1_end;
    endsequence

    sequence cp_released;
        copro_request_n && cp_state == cbs_pkg::CBS_CP_IDLE;
    endsequence

    wdata_hold_a: assert property (!cyc_end |=> $stable(data_out))
        else $error("write data changed outside a cycle end");

    lock_swap_a: assert property ($rose(ctl_pins.lock) |-> $past(swap_instr))
        else $error("lock rose without a swap");

    lock_mclk_a: assert property ($changed(ctl_pins.lock) |-> $past(addr_open))
        else $error("lock changed while clock low or hold closed");

    float_abe_a: assert property (
        !addr_bus_drive_en |=> !ctl_pins.bw_oe && !ctl_pins.lock_oe)
        else $error("controls driven while drive enable low");

    bw_value_a: assert property (
        addr_open |=> ctl_pins.bw_n == $past(next_xfer.word))
        else $error("byte/word does not follow transfer size");

    bw_stable_a: assert property (!mclk |=> $stable(ctl_pins.bw_n))
        else $error("byte/word changed in phase 1");

    copro_absent_a: assert property (
        cp_first_sample ##0 copro_absent |=> copro_trap ##0 cp_released)
        else $error("absent coprocessor did not trap");

    copro_busy_a: assert property (
        (cp_req || cp_wait) && ph1_end && !copro_absent && copro_busy
        |=> !copro_request_n && !copro_done)
        else $error("request dropped while coprocessor busy");

    drive_en_a: assert property (cyc_end |=> out_drive_en_n == $past(next_drive_n))
        else $error("drive enable wrong for cycle");

    fiq_take_a: assert property ((!fast_intr_req_n && fiq_enable) [*3] |=> fiq_take)
        else $error("fast interrupt not taken");

    irq_prio_a: assert property (fiq_take |-> !irq_take)
        else $error("standard interrupt taken over fast one");

    mode_inv_a: assert property (1'b1 |=> mode_status_n == ~$past(cpu_mode))
        else $error("mode outputs not inverted mode");

endmodule

// ---- design/cbs_consts.svh ----
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define CBS_DATA_W 32
`define CBS_MODE_W 5
`define CBS_SYNC_W 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CBS_DATA_RST 32'h0000_0000
`define CBS_MODE_N_RST 5'h1f
`define CBS_SYNC_RST 2'h3

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CBS_CLK_PERIOD_NS 25
`define CBS_SYNC_STAGES 2

`endif

// ---- design/cbs_pkg.sv ----
`include "cbs_consts.svh"

package cbs_pkg;

    // Transfer that the core wants for the following bus cycle.
    typedef struct packed {
        logic write;
        logic word;
        logic [`CBS_DATA_W-1:0] wdata;
    } cbs_xfer_t;

    // Pin-side bus outputs, each tristated pin as value and enable.
    typedef struct packed {
        logic bw_n;
        logic bw_oe;
        logic lock;
        logic lock_oe;
    } cbs_ctl_pins_t;

    typedef enum logic [1:0] {
        CBS_CP_IDLE,
        CBS_CP_REQ,
        CBS_CP_WAIT
    } cbs_cp_state_t;

endpackage

// ---- design/cbs_sync.sv ----
`timescale 1ns/100ps
`include "cbs_consts.svh"

// Two-stage synchroniser for active-low request levels; resets to idle (high).
module cbs_sync
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [`CBS_SYNC_W-1:0] async_in,
    output logic [`CBS_SYNC_W-1:0] sync_out
);

    logic [`CBS_SYNC_W-1:0] stage1;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            stage1 <= `CBS_SYNC_RST;
            sync_out <= `CBS_SYNC_RST;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ---- sim/cbs_copro_model.sv ----
`timescale 1ns/100ps

// Coprocessor that answers at once or after busy_cycles clocks of busy.
module cbs_copro_model
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic copro_request_n,
    input wire logic absent_mode,
    input wire logic [7:0] busy_cycles,
    output logic copro_absent,
    output logic copro_busy
);
    logic [7:0] wait_cnt = 8'h00;
    logic noise = 1'b0;

    always_ff @(posedge clock)
    begin
        wait_cnt <= (!rst_b || copro_request_n) ? 8'h00 : wait_cnt + {7'h00, wait_cnt != 8'hff};
        noise <= rst_b && !noise;
    end

    // Busy toggles outside a handshake, so a core that samples it early is caught.
    assign copro_absent = absent_mode;
    assign copro_busy = copro_request_n ? noise : (wait_cnt < busy_cycles);
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
`include "cbs_consts.svh"

module tb_top;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic mclk = 1'b0, stall_req_n = 1'b1, addr_bus_drive_en = 1'b1, addr_hold_en = 1'b1;
    logic in_drive_en_n = 1'b1, fast_intr_req_n = 1'b1, std_intr_req_n = 1'b1;
    logic swap_instr = 1'b0, copro_start = 1'b0, fiq_enable = 1'b0, irq_enable = 1'b0;
    logic absent_mode = 1'b0, copro_absent, copro_busy;
    logic [7:0] busy_cycles = 8'h00;
    logic [4:0] cpu_mode = 5'h00;
    cbs_pkg::cbs_xfer_t next_xfer = '0;
    cbs_pkg::cbs_ctl_pins_t ctl_pins;
    logic write_not_read, out_drive_en_n, copro_request_n, copro_trap, copro_done;
    logic fiq_take, irq_take;
    logic [31:0] data_out;
    logic [4:0] mode_status_n;
    int n_mismatch = 0, tests_run = 0;
    bit [31:0] seed = 32'h0000_0045, r, q;
    bit [7:0] thr_tab[4] = '{8'hff, 8'h40, 8'h04, 8'h80};
    bit armed, pm, pph2, ph1, cyc, lat, f1, f2, i1, i2;
    bit e_bw, e_lock, e_oe, e_wnr, e_oen, e_req, e_trap, e_done, e_fiq, e_irq;
    bit [31:0] e_data;
    bit [4:0] e_mode;
    // Far-side models: external buffers onto a shared data bus, and a memory
    // controller that grants a second master only while no lock is driven.
    wire [31:0] shared_bus = out_drive_en_n ? 32'hzzzz_zzzz : data_out;
    wire other_grant = !(ctl_pins.lock && ctl_pins.lock_oe);

    always #12.5 clock = !clock;

    cbs_bus_side dut_u
    (
        .clock, .rst_b, .mclk, .stall_req_n, .addr_bus_drive_en, .addr_hold_en,
        .in_drive_en_n, .copro_absent, .copro_busy, .fast_intr_req_n, .std_intr_req_n,
        .next_xfer, .swap_instr, .copro_start, .fiq_enable, .irq_enable, .cpu_mode,
        .ctl_pins, .write_not_read, .data_out, .out_drive_en_n, .copro_request_n,
        .copro_trap, .copro_done, .fiq_take, .irq_take, .mode_status_n
    );

    cbs_copro_model copro_u
    (
        .clock, .rst_b, .copro_request_n, .absent_mode, .busy_cycles, .copro_absent, .copro_busy
    );

    function bit [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task check(input logic [32:0] got, input logic [32:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task check_ctl();
        check({ctl_pins, write_not_read}, {e_bw, e_oe, e_lock, e_oe, e_wnr}, "ctl");
        check(other_grant, !(e_lock && e_oe), "grant");
    endtask

    task check_wdata();
        check({out_drive_en_n, data_out}, {e_oen, e_data}, "wdata");
        check({1'b0, shared_bus}, {1'b0, e_oen ? 32'hzzzz_zzzz : e_data}, "bus");
    endtask

    task check_copro();
        check({copro_request_n, copro_trap, copro_done}, {e_req, e_trap, e_done}, "copro");
    endtask

    task check_intr();
        check({fiq_take, irq_take}, {e_fiq, e_irq}, "intr");
    endtask

    task check_mode();
        check(mode_status_n, e_mode, "mode");
    endtask

    task final_report();
        $display("Compared %0d results, %0d mismatches", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // The model runs on the edge itself, so like the design it sees every
    // value as it stood just before that edge.
    always @(posedge clock)
    begin
        armed = armed || !rst_b;
        ph1 = mclk && !pm;
        cyc = !mclk && pph2;
        lat = mclk && addr_hold_en;
        e_oen = !rst_b || (cyc ? !(e_wnr && !in_drive_en_n) : e_oen);
        e_data = !rst_b ? `CBS_DATA_RST : (cyc && e_wnr) ? next_xfer.wdata : e_data;
        e_bw = rst_b && (lat ? next_xfer.word : e_bw);
        e_lock = rst_b && (lat ? swap_instr : e_lock);
        e_wnr = rst_b && (lat ? next_xfer.write : e_wnr);
        e_oe = rst_b && addr_bus_drive_en;
        e_trap = rst_b && !e_req && ph1 && copro_absent;
        e_done = rst_b && !e_req && ph1 && !copro_absent && !copro_busy;
        e_req = !rst_b || e_trap || e_done || (e_req && !(cyc && copro_start));
        e_fiq = rst_b && !f2 && fiq_enable;
        e_irq = rst_b && !i2 && irq_enable && !(!f2 && fiq_enable);
        f2 = !rst_b || f1;
        f1 = !rst_b || fast_intr_req_n;
        i2 = !rst_b || i1;
        i1 = !rst_b || std_intr_req_n;
        e_mode = rst_b ? ~cpu_mode : `CBS_MODE_N_RST;
        pm = mclk;
        pph2 = mclk && stall_req_n;
    end

    always @(negedge clock)
    begin
        if (armed)
        begin
            check_ctl();
            check_wdata();
            check_copro();
            check_intr();
            check_mode();
        end
    end

    task step(input bit [7:0] thr);
        @(posedge clock);
        #2;
        r = xs();
        q = xs();
        if (!mclk)
        begin
            stall_req_n = r[8] || r[9];
        end
        mclk = (r[7:0] < thr) ? !mclk : mclk;
        addr_hold_en = r[10] || r[11];
        addr_bus_drive_en = r[12] || r[13];
        in_drive_en_n = r[14];
        next_xfer = {r[15], r[16], q};
        swap_instr = r[17] && r[18];
        fiq_enable = r[19] || r[20];
        irq_enable = r[21] || r[22];
        cpu_mode = r[27:23];
        fast_intr_req_n = fiq_take || (fast_intr_req_n && (r[30:28] != 3'h0));
        std_intr_req_n = irq_take || (std_intr_req_n && (q[2:0] != 3'h0));
        if (copro_request_n && !copro_start)
        begin
            absent_mode = (q[6:3] == 4'h0);
            busy_cycles = {4'h0, q[10:7]};
        end
        copro_start = copro_request_n && (copro_start || r[31]);
    endtask

    // Requests are parked idle while reset is low so no stale transfer survives it.
    task do_reset();
        @(posedge clock);
        #2;
        rst_b = 1'b0;
        mclk = 1'b0;
        stall_req_n = 1'b1;
        fast_intr_req_n = 1'b1;
        std_intr_req_n = 1'b1;
        copro_start = 1'b0;
        repeat (16) @(posedge clock);
        #2;
        rst_b = 1'b1;
    endtask

    initial
    begin
        do_reset();
        for (int s = 0; s < 4; s++)
        begin
            repeat (3000) step(thr_tab[s]);
            if (s == 1)
            begin
                do_reset();
            end
        end
        final_report();
    end

    initial
    begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule
